/* File: src/psc_pipe_ctrl.sv */
// Added by the designer: the plain strobed port and the placing of the registers.
module psc_pipe_ctrl
    import psc_pkg::*;
#(
    parameter int HAS_HW_MUL = 1,
    parameter int MUL_EMBEDDED = 1,
    parameter int HAS_DIV = 1,
    parameter int HAS_CUSTOM_MC = 1,
    parameter int IDX_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // instruction from fetch unit
    input wire logic f_in_valid,
    input wire psc_class_type f_in_cls,
    input wire logic [4:0] f_in_dst,
    input wire logic [4:0] f_in_src_a,
    input wire logic [4:0] f_in_src_b,
    input wire logic f_in_use_a,
    input wire logic f_in_use_b,
    input wire logic [IDX_W-1:0] f_in_idx,
    input wire logic f_in_backward,
    output logic f_ready,
    // redirect toward fetch unit
    output logic pred_redirect,
    output logic flush_out,
    // branch outcome for the memory-stage branch
    input wire logic m_br_taken,
    // align-stage completion sources
    input wire logic dbus_pending,
    input wire logic shift_busy,
    input wire logic div_busy,
    input wire logic ci_stall,
    // memory request permit and retirement
    output logic m_mem_req,
    output logic w_retire,
    output logic w_wr_en,
    output logic [4:0] w_dst,
    output logic [NUM_STAGES-1:0] stage_valid,
    // register port
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    // per-stage payload
    logic vld_ff [NUM_STAGES];
    psc_class_type cls_ff [NUM_STAGES];
    logic [4:0] dst_ff [NUM_STAGES];
    logic [4:0] sa_ff [NUM_STAGES];
    logic [4:0] sb_ff [NUM_STAGES];
    logic ua_ff [NUM_STAGES];
    logic ub_ff [NUM_STAGES];
    logic pred_ff [NUM_STAGES];
    logic [IDX_W-1:0] idx_ff [NUM_STAGES];
    logic nxt_vld [NUM_STAGES];
    psc_class_type nxt_cls [NUM_STAGES];
    logic [4:0] nxt_dst [NUM_STAGES];
    logic [4:0] nxt_sa [NUM_STAGES];
    logic [4:0] nxt_sb [NUM_STAGES];
    logic nxt_ua [NUM_STAGES];
    logic nxt_ub [NUM_STAGES];
    logic nxt_pred [NUM_STAGES];
    logic [IDX_W-1:0] nxt_idx [NUM_STAGES];
    logic f_bwd_ff;
    logic d_bwd_ff;
    logic [1:0] cfg_ff;
    logic extra_ff;
    logic [1:0] a_cnt_ff;
    logic [31:0] retired_ff;
    logic [31:0] stalls_ff;
    logic [31:0] rdata_ff;

    // late-result classes; load, shift and rdctl always, mul, div and custom multicycle only where their option exists
    function automatic logic is_late(input psc_class_type c);
        is_late = (c == CLS_LOAD) || (c == CLS_SHIFT) || (c == CLS_RDCTL)
               || ((c == CLS_MUL) && (HAS_HW_MUL != 0))
               || ((c == CLS_DIV) && (HAS_DIV != 0))
               || ((c == CLS_CUSTOM_MC) && (HAS_CUSTOM_MC != 0));
    endfunction

    // decode reads a late result held by stage s
    function automatic logic dep_on(input int s);
        dep_on = vld_ff[s] && is_late(cls_ff[s]) && (dst_ff[s] != 5'h00)
              && ((ua_ff[STG_D] && (sa_ff[STG_D] == dst_ff[s]))
              || (ub_ff[STG_D] && (sb_ff[STG_D] == dst_ff[s])));
    endfunction

    // align-stage stall sources
    wire a_vld = vld_ff[STG_A];
    wire psc_class_type a_cls = cls_ff[STG_A];
    wire a_mem = (a_cls == CLS_LOAD) || (a_cls == CLS_STORE)
              || (a_cls == CLS_DC_FLUSH) || (a_cls == CLS_DC_INIT);
    wire a_shift_le = (HAS_HW_MUL != 0) && (MUL_EMBEDDED == 0);
    wire [1:0] a_need = ((a_cls == CLS_SHIFT) && a_shift_le) ? SHIFT_LE_EXTRA
                      : ((a_cls == CLS_DC_FLUSH) || (a_cls == CLS_DC_INIT)) ? DC_OP_EXTRA
                      : 2'h0;
    wire a_wait_bus = a_mem && dbus_pending;
    wire a_wait_shift = (a_cls == CLS_SHIFT) && (HAS_HW_MUL == 0) && shift_busy;
    wire a_wait_div = (a_cls == CLS_DIV) && (HAS_DIV != 0) && div_busy;
    wire a_wait_ci = (a_cls == CLS_CUSTOM_MC) && ci_stall;
    wire a_wait_fix = a_cnt_ff < a_need;
    wire stall_a = a_vld && (a_wait_bus || a_wait_shift || a_wait_div || a_wait_ci
                          || a_wait_fix);

    // memory-stage flush request: flush class, icache op or mispredict
    wire m_vld = vld_ff[STG_M];
    wire m_is_br = m_vld && (cls_ff[STG_M] == CLS_BRANCH);
    wire m_mispred = m_is_br && (pred_ff[STG_M] != m_br_taken);
    wire m_flush_req = m_mispred
                    || (m_vld && ((cls_ff[STG_M] == CLS_FLUSH)
                    || (cls_ff[STG_M] == CLS_IC_OP)));
    wire flush_go = m_flush_req && !stall_a;

    // decode interlock: producer in execute or memory is still too close
    wire stall_d = vld_ff[STG_D] && !m_flush_req
                && (dep_on(STG_E) || dep_on(STG_M));
    wire hold_fd = stall_a || stall_d;

    // prediction for the decode-stage branch
    logic dyn_taken;
    wire d_is_br = vld_ff[STG_D] && (cls_ff[STG_D] == CLS_BRANCH);
    wire d_pred = cfg_ff[CTRL_DYN_PRED_BIT] ? dyn_taken : d_bwd_ff;
    wire d_redirect = d_is_br && d_pred && !hold_fd && !flush_go;

    // a flush restarts fetch in its own cycle; the extended features cost one more
    wire flush_refuse = flush_go && cfg_ff[CTRL_EXT_FEAT_BIT];
    wire f_accept_ok = !hold_fd && !flush_refuse;
    wire f_take = f_in_valid && f_accept_ok;

    assign f_ready = f_accept_ok;
    assign pred_redirect = d_redirect;
    assign flush_out = flush_go;

    psc_branch_table #(
        .IDX_W(IDX_W)
    ) u_table (
        .clk(clk),
        .rst_b(rst_b),
        .rd_idx(idx_ff[STG_D]),
        .rd_taken(dyn_taken),
        .upd_en(m_is_br && !stall_a),
        .upd_idx(idx_ff[STG_M]),
        .upd_taken(m_br_taken)
    );

    // next-state of the stage chain; holds by default
    always_comb begin
        for (int i = 0; i < NUM_STAGES; i++) begin
            nxt_vld[i] = vld_ff[i];
            nxt_cls[i] = cls_ff[i];
            nxt_dst[i] = dst_ff[i];
            nxt_sa[i] = sa_ff[i];
            nxt_sb[i] = sb_ff[i];
            nxt_ua[i] = ua_ff[i];
            nxt_ub[i] = ub_ff[i];
            nxt_pred[i] = pred_ff[i];
            nxt_idx[i] = idx_ff[i];
        end
        // writeback drains even under an align stall
        nxt_vld[STG_W] = stall_a ? 1'b0 : vld_ff[STG_A];
        if (!stall_a) begin
            for (int i = STG_E; i <= STG_W; i++) begin
                nxt_cls[i] = cls_ff[i-1];
                nxt_dst[i] = dst_ff[i-1];
                nxt_sa[i] = sa_ff[i-1];
                nxt_sb[i] = sb_ff[i-1];
                nxt_ua[i] = ua_ff[i-1];
                nxt_ub[i] = ub_ff[i-1];
                nxt_pred[i] = pred_ff[i-1];
                nxt_idx[i] = idx_ff[i-1];
            end
            nxt_vld[STG_A] = vld_ff[STG_M];
            nxt_vld[STG_M] = vld_ff[STG_E] && !flush_go;
            nxt_vld[STG_E] = vld_ff[STG_D] && !stall_d && !flush_go;
            nxt_pred[STG_E] = d_pred;
            if (!stall_d) begin
                nxt_cls[STG_D] = cls_ff[STG_F];
                nxt_dst[STG_D] = dst_ff[STG_F];
                nxt_sa[STG_D] = sa_ff[STG_F];
                nxt_sb[STG_D] = sb_ff[STG_F];
                nxt_ua[STG_D] = ua_ff[STG_F];
                nxt_ub[STG_D] = ub_ff[STG_F];
                nxt_idx[STG_D] = idx_ff[STG_F];
                // a predicted-taken branch drops its sequential follower
                nxt_vld[STG_D] = vld_ff[STG_F] && !flush_go && !d_redirect;
                nxt_vld[STG_F] = f_take;
                nxt_cls[STG_F] = f_in_cls;
                nxt_dst[STG_F] = f_in_dst;
                nxt_sa[STG_F] = f_in_src_a;
                nxt_sb[STG_F] = f_in_src_b;
                nxt_ua[STG_F] = f_in_use_a;
                nxt_ub[STG_F] = f_in_use_b;
                nxt_idx[STG_F] = f_in_idx;
            end
        end
    end

    // stage registers; a stall keeps every held stage as it was
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_STAGES; i++) begin
                vld_ff[i] <= 1'b0;
                cls_ff[i] <= CLS_ALU;
                dst_ff[i] <= 5'h00;
                sa_ff[i] <= 5'h00;
                sb_ff[i] <= 5'h00;
                ua_ff[i] <= 1'b0;
                ub_ff[i] <= 1'b0;
                pred_ff[i] <= 1'b0;
                idx_ff[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_STAGES; i++) begin
                vld_ff[i] <= nxt_vld[i];
                cls_ff[i] <= nxt_cls[i];
                dst_ff[i] <= nxt_dst[i];
                sa_ff[i] <= nxt_sa[i];
                sb_ff[i] <= nxt_sb[i];
                ua_ff[i] <= nxt_ua[i];
                ub_ff[i] <= nxt_ub[i];
                pred_ff[i] <= nxt_pred[i];
                idx_ff[i] <= nxt_idx[i];
            end
        end
    end

    // static hint travels with the fetch-stage instruction into decode
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            f_bwd_ff <= 1'b0;
            d_bwd_ff <= 1'b0;
        end else if (!hold_fd) begin
            f_bwd_ff <= f_in_backward;
            d_bwd_ff <= f_bwd_ff;
        end
    end

    // remembers the fetch refused by an extended flush, for the status word
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            extra_ff <= 1'b0;
        end else begin
            extra_ff <= flush_refuse;
        end
    end

    // cycles spent by the current align-stage instruction
    wire a_new = !stall_a;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            a_cnt_ff <= 2'h0;
        end else if (a_new) begin
            a_cnt_ff <= 2'h0;
        end else if (a_wait_fix) begin
            a_cnt_ff <= a_cnt_ff + 2'h1;
        end
    end

    // only valid instructions reach memory and the register file
    wire m_is_mem = (cls_ff[STG_M] == CLS_LOAD) || (cls_ff[STG_M] == CLS_STORE)
                 || (cls_ff[STG_M] == CLS_DC_FLUSH) || (cls_ff[STG_M] == CLS_DC_INIT);
    wire w_writes = (dst_ff[STG_W] != 5'h00) && (cls_ff[STG_W] != CLS_STORE)
                 && (cls_ff[STG_W] != CLS_BRANCH) && (cls_ff[STG_W] != CLS_FLUSH)
                 && (cls_ff[STG_W] != CLS_DC_FLUSH) && (cls_ff[STG_W] != CLS_DC_INIT)
                 && (cls_ff[STG_W] != CLS_IC_OP);
    assign m_mem_req = m_vld && m_is_mem;
    assign w_retire = vld_ff[STG_W];
    assign w_wr_en = vld_ff[STG_W] && w_writes;
    assign w_dst = dst_ff[STG_W];

    // stage occupancy vector, fetch in bit 0
    genvar g;
    generate
        for (g = 0; g < NUM_STAGES; g++) begin : g_vld
            assign stage_valid[g] = vld_ff[g];
        end
    endgenerate

    // register decode
    wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
    wire wr_retired = reg_wr && (reg_addr == REG_RETIRED);
    wire wr_stalls = reg_wr && (reg_addr == REG_STALLS);
    wire [31:0] status_word = {21'h00_0000, extra_ff, stall_d, stall_a, 2'h0,
                               stage_valid};
    wire [31:0] rd_mux = (reg_addr == REG_CTRL) ? {30'h0000_0000, cfg_ff}
                       : (reg_addr == REG_STATUS) ? status_word
                       : (reg_addr == REG_RETIRED) ? retired_ff
                       : (reg_addr == REG_STALLS) ? stalls_ff
                       : 32'h0000_0000;

    // control register steers prediction mode and flush length
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff <= CTRL_RESET;
        end else if (wr_ctrl) begin
            cfg_ff <= reg_wdata[1:0];
        end
    end

    // counters: a write clears; a retire in the same cycle still counts
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            retired_ff <= 32'h0000_0000;
            stalls_ff <= 32'h0000_0000;
        end else begin
            retired_ff <= (wr_retired ? 32'h0000_0000 : retired_ff) + {31'h0000_0000, w_retire};
            stalls_ff <= (wr_stalls ? 32'h0000_0000 : stalls_ff) + {31'h0000_0000, hold_fd};
        end
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end
    assign reg_rdata = rdata_ff;

endmodule

/* File: src/psc_pkg.sv */
package psc_pkg;

    // instruction classes as seen by the pipeline control
    typedef enum logic [3:0] {
        CLS_ALU,
        CLS_LOAD,
        CLS_STORE,
        CLS_SHIFT,
        CLS_MUL,
        CLS_DIV,
        CLS_RDCTL,
        CLS_CUSTOM_MC,
        CLS_BRANCH,
        CLS_FLUSH,
        CLS_DC_FLUSH,
        CLS_DC_INIT,
        CLS_IC_OP
    } psc_class_type;

    // stage indices, oldest at the highest index
    localparam int NUM_STAGES = 6;
    localparam int STG_F = 0;
    localparam int STG_D = 1;
    localparam int STG_E = 2;
    localparam int STG_M = 3;
    localparam int STG_A = 4;
    localparam int STG_W = 5;

    // register byte offsets on the plain register port
    localparam int REG_ADDR_W = 4;
    localparam logic [REG_ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [REG_ADDR_W-1:0] REG_RETIRED = 4'h8;
    localparam logic [REG_ADDR_W-1:0] REG_STALLS = 4'hc;

    // control register fields and reset value
    localparam int CTRL_DYN_PRED_BIT = 0;
    localparam int CTRL_EXT_FEAT_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;

    // status register field positions
    localparam int STAT_VLD_LSB = 0;
    localparam int STAT_STALL_A_BIT = 8;
    localparam int STAT_STALL_D_BIT = 9;
    localparam int STAT_EXTRA_BIT = 10;

    // extra align-stage cycles for fixed multicycle operations
    localparam logic [1:0] SHIFT_LE_EXTRA = 2'h1;
    localparam logic [1:0] DC_OP_EXTRA = 2'h1;

    // predictor counter reset value: weakly not taken
    localparam logic [1:0] PRED_RESET = 2'h1;

endpackage

/* File: src/psc_branch_table.sv */
// table of two-bit saturating counters, one read and one update port
module psc_branch_table
    import psc_pkg::*;
#(
    parameter int IDX_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // lookup
    input wire logic [IDX_W-1:0] rd_idx,
    output logic rd_taken,
    // update at resolution
    input wire logic upd_en,
    input wire logic [IDX_W-1:0] upd_idx,
    input wire logic upd_taken
);

    localparam int DEPTH = 1 << IDX_W;

    logic [1:0] cnt_ff [DEPTH];
    logic [1:0] cur_cnt;
    logic [1:0] nxt_cnt;

    // msb of the counter is the prediction
    assign rd_taken = cnt_ff[rd_idx][1];
    assign cur_cnt = cnt_ff[upd_idx];
    // saturate at both ends so one odd outcome does not flip a strong entry
    assign nxt_cnt = upd_taken ? ((cur_cnt == 2'h3) ? cur_cnt : cur_cnt + 2'h1)
                               : ((cur_cnt == 2'h0) ? cur_cnt : cur_cnt - 2'h1);

    // counter storage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < DEPTH; i++) begin
                cnt_ff[i] <= PRED_RESET;
            end
        end else if (upd_en) begin
            cnt_ff[upd_idx] <= nxt_cnt;
        end
    end

endmodule

/* File: verification/psc_pipe_monitor.sv */
module psc_pipe_monitor
    import psc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // align completion sources
    input wire logic dbus_pending,
    input wire logic div_busy,
    input wire logic ci_stall,
    input wire logic f_in_valid,
    // pipeline outputs
    input wire logic f_ready,
    input wire logic pred_redirect,
    input wire logic flush_out,
    input wire logic m_mem_req,
    input wire logic w_retire,
    input wire logic w_wr_en,
    input wire logic [4:0] w_dst,
    input wire logic [NUM_STAGES-1:0] stage_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // an align stall as seen from the completion sources
    wire align_wait = (dbus_pending | div_busy | ci_stall) & stage_valid[STG_A];

    property p_retire_w;
        w_retire |-> stage_valid[STG_W];
    endproperty
    a_retire_w: assert property (p_retire_w)
        else $error("retire without a writeback entry");
    property p_wr_en;
        w_wr_en |-> w_retire && (w_dst != 5'h00);
    endproperty
    a_wr_en: assert property (p_wr_en)
        else $error("register write without a valid retire");
    property p_hold;
        align_wait |=> !stage_valid[STG_W] && $stable(stage_valid[STG_A:STG_F]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("align stall did not hold the earlier stages");
    property p_refuse;
        align_wait |-> !f_ready;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("fetch accepted during an align stall");
    property p_flush_refuse;
        flush_out |=> stage_valid[STG_F] == $past(f_in_valid && f_ready);
    endproperty
    a_flush_refuse: assert property (p_flush_refuse)
        else $error("fetch entry after a flush is not the restart");
    property p_flush_cancel;
        flush_out |=> stage_valid[STG_M:STG_D] == 3'h0;
    endproperty
    a_flush_cancel: assert property (p_flush_cancel)
        else $error("younger entries survived a flush");
    property p_flush_drain;
        flush_out |-> ##2 w_retire;
    endproperty
    a_flush_drain: assert property (p_flush_drain)
        else $error("flushing entry did not retire two cycles later");
    property p_no_compact;
        stage_valid[STG_F] && !f_ready && !flush_out |=> stage_valid[STG_F];
    endproperty
    a_no_compact: assert property (p_no_compact)
        else $error("stalled fetch entry moved on");
    property p_redirect;
        pred_redirect |-> f_ready && stage_valid[STG_D];
    endproperty
    a_redirect: assert property (p_redirect)
        else $error("redirect without an advancing decode entry");
    property p_mem_req;
        m_mem_req |-> stage_valid[STG_M];
    endproperty
    a_mem_req: assert property (p_mem_req)
        else $error("memory request from an empty memory stage");
endmodule

bind psc_pipe_ctrl psc_pipe_monitor u_mon (
    .clk(clk), .rst_b(rst_b), .dbus_pending(dbus_pending), .div_busy(div_busy),
    .ci_stall(ci_stall), .f_in_valid(f_in_valid), .f_ready(f_ready),
    .pred_redirect(pred_redirect),
    .flush_out(flush_out), .m_mem_req(m_mem_req), .w_retire(w_retire),
    .w_wr_en(w_wr_en), .w_dst(w_dst), .stage_valid(stage_valid)
);

/* File: verification/psc_far_end.sv */
module psc_far_end
    import psc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // instruction accepted at fetch
    input wire logic take,
    input wire psc_class_type cls,
    // wait lengths ordered by the bench
    input wire logic [3:0] bus_wait,
    input wire logic [3:0] unit_wait,
    // completion sources toward the align stage
    output logic dbus_pending,
    output logic shift_busy,
    output logic div_busy,
    output logic ci_stall
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] vld_ff;
    psc_class_type cls_ff [4];
    psc_class_type a_cls_ff;
    logic [3:0] cnt_ff;
    wire busy = cnt_ff != 4'h0;
    wire is_mem = cls_ff[3] inside {CLS_LOAD, CLS_STORE};
    wire is_unit = cls_ff[3] inside {CLS_DIV, CLS_CUSTOM_MC};
    wire [3:0] need = is_mem ? bus_wait : (is_unit ? unit_wait : 4'h0);
    // tracks entries to align by count alone: stalls ahead of align are not followed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vld_ff <= 4'h0;
            cnt_ff <= 4'h0;
            a_cls_ff <= CLS_ALU;
        end else begin
            vld_ff <= {vld_ff[2:0], take};
            cls_ff <= '{cls, cls_ff[0], cls_ff[1], cls_ff[2]};
            if (vld_ff[3] && need != 4'h0) begin
                a_cls_ff <= cls_ff[3];
                cnt_ff <= need;
            end else if (busy) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
    // each source but shift_busy, which never rises, stays up until its result is ready, only for its own class
    assign dbus_pending = busy && a_cls_ff inside {CLS_LOAD, CLS_STORE};
    assign div_busy = busy && a_cls_ff == CLS_DIV;
    assign ci_stall = busy && a_cls_ff == CLS_CUSTOM_MC;
    assign shift_busy = busy && a_cls_ff == CLS_SHIFT;
endmodule

/* File: verification/tb_top.sv */
module tb_top import psc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAT = 6; // acceptance edge to the edge that sees the retire
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic f_in_valid = 1'b0;
    psc_class_type f_in_cls = CLS_ALU;
    logic [4:0] f_in_dst = 5'h00;
    logic [4:0] f_in_src_a = 5'h00;
    logic f_in_use_a = 1'b0;
    logic f_in_backward = 1'b0;
    logic m_br_taken = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] bus_wait = 4'h0;
    logic [3:0] unit_wait = 4'h3;
    logic f_ready, pred_redirect, flush_out, m_mem_req, w_retire, w_wr_en;
    logic dbus_pending, shift_busy, div_busy, ci_stall;
    logic [4:0] w_dst;
    logic [5:0] stage_valid;
    logic [31:0] reg_rdata;
    int cyc = 0;
    int n_errors = 0;
    int n_checks = 0;
    int rq[$];
    int aq[$];
    logic [4:0] dq[$];
    psc_class_type cl[3] = '{CLS_LOAD, CLS_CUSTOM_MC, CLS_DIV};

    psc_pipe_ctrl u_dut (
        .clk(clk), .rst_b(rst_b), .f_in_valid(f_in_valid), .f_in_cls(f_in_cls),
        .f_in_dst(f_in_dst), .f_in_src_a(f_in_src_a), .f_in_src_b(5'h00),
        .f_in_use_a(f_in_use_a), .f_in_use_b(1'b0), .f_in_idx(8'h00),
        .f_in_backward(f_in_backward), .f_ready(f_ready), .pred_redirect(pred_redirect),
        .flush_out(flush_out), .m_br_taken(m_br_taken), .dbus_pending(dbus_pending),
        .shift_busy(shift_busy), .div_busy(div_busy), .ci_stall(ci_stall),
        .m_mem_req(m_mem_req), .w_retire(w_retire), .w_wr_en(w_wr_en), .w_dst(w_dst),
        .stage_valid(stage_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );
    psc_far_end u_far (
        .clk(clk), .rst_b(rst_b), .take(f_in_valid & f_ready), .cls(f_in_cls),
        .bus_wait(bus_wait), .unit_wait(unit_wait), .dbus_pending(dbus_pending),
        .shift_busy(shift_busy), .div_busy(div_busy), .ci_stall(ci_stall)
    );

    always #2 clk = ~clk;
    // retire log; retire is registered, so reading it at the edge is race free
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (w_retire === 1'b1) begin
            rq.push_back(cyc);
            dq.push_back(w_dst);
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, e);
        @(posedge clk);
    endtask
    // valid is left high so back-to-back issues never touch it twice in one step
    task automatic issue(input psc_class_type c, input int d, input int s, input logic bk);
        logic g;
        f_in_valid <= 1'b1;
        f_in_cls <= c;
        f_in_dst <= 5'(d);
        f_in_src_a <= 5'(s);
        f_in_use_a <= (s != 0);
        f_in_backward <= bk;
        g = 1'b0;
        for (int i = 0; i < 50 && !g; i++) begin
            @(negedge clk);
            g = f_ready;
            @(posedge clk);
        end
        aq.push_back(cyc);
    endtask
    task automatic idle(input int n);
        f_in_valid <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic clr();
        rq.delete();
        dq.delete();
        aq.delete();
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // bounded by about sixteen times the expected run length
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rd(REG_CTRL, 32'h0000_0001);
        rd(REG_STATUS, 32'h0000_0000);
        wr(4'h2, 32'hffff_ffff);
        rd(4'h2, 32'h0000_0000);
        // straight-line code streams one per cycle
        clr();
        for (int i = 1; i < 5; i++) issue(CLS_ALU, i, 0, 1'b0);
        idle(20);
        chk(rq[0] - aq[0], LAT);
        for (int i = 1; i < 4; i++) chk(rq[i] - rq[0], i);
        for (int i = 0; i < 4; i++) chk(dq[i], 32'(i + 1));
        rd(REG_RETIRED, 32'h0000_0004);
        // load-use interlock costs exactly two cycles
        wr(REG_STALLS, 32'h0000_0000);
        clr();
        issue(CLS_LOAD, 5, 0, 1'b0);
        issue(CLS_ALU, 6, 5, 1'b0);
        idle(20);
        chk(rq[0] - aq[0], LAT);
        chk(rq[1] - rq[0], 3);
        rd(REG_STALLS, 32'h0000_0002);
        // align waits on the bus, the custom unit and the divider
        bus_wait <= 4'h3;
        for (int k = 0; k < 3; k++) begin
            clr();
            issue(cl[k], 7, 0, 1'b0);
            for (int i = 0; i < 4; i++) issue(CLS_ALU, 8, 0, 1'b0);
            idle(25);
            chk(rq[0] - aq[0], LAT + 3);
            chk(rq[4] - rq[0], 4);
        end
        // correctly predicted not taken, then a mispredict with three victims
        clr();
        issue(CLS_BRANCH, 0, 0, 1'b0);
        issue(CLS_ALU, 9, 0, 1'b0);
        idle(20);
        chk(rq[1] - rq[0], 1);
        m_br_taken <= 1'b1;
        clr();
        issue(CLS_BRANCH, 0, 0, 1'b0);
        for (int i = 0; i < 3; i++) issue(CLS_ALU, 10, 0, 1'b0);
        issue(CLS_ALU, 11, 0, 1'b0);
        idle(20);
        chk(rq.size(), 2);
        chk(rq[1] - rq[0], 4);
        chk(dq[1], 32'h0000_000b);
        // one more taken outcome lifts the shared counter to weakly taken
        clr();
        issue(CLS_BRANCH, 0, 0, 1'b0);
        idle(20);
        chk(rq.size(), 1);
        // predicted taken: by the trained counter, then by the static hint
        for (int j = 0; j < 2; j++) begin
            wr(REG_CTRL, {31'h0000_0000, ~j[0]});
            clr();
            issue(CLS_BRANCH, 0, 0, j[0]);
            issue(CLS_ALU, 12, 0, 1'b0);
            issue(CLS_ALU, 13, 0, 1'b0);
            idle(20);
            chk(rq.size(), 2);
            chk(rq[1] - rq[0], 2);
            chk(dq[1], 32'h0000_000d);
        end
        // extended features: a flush-class op takes five cycles
        wr(REG_CTRL, 32'h0000_0003);
        clr();
        issue(CLS_FLUSH, 0, 0, 1'b0);
        for (int i = 0; i < 3; i++) issue(CLS_ALU, 10, 0, 1'b0);
        issue(CLS_ALU, 14, 0, 1'b0);
        idle(20);
        chk(rq.size(), 2);
        chk(rq[1] - rq[0], 5);
        chk(dq[1], 32'h0000_000e);
        wrap_up();
    end
endmodule
